// [hdl/cs_status_buffer.sv]
// channel-status capture and host buffer with serial status output
`timescale 1ns/100ps
`include "cs_buffer_cfg.svh"
module cs_status_buffer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic strapped_mode,
  input wire logic port_master,
  input wire logic output_frame_clock,
  input wire logic cs_valid,
  input wire logic cs_bit_a,
  input wire logic cs_bit_b,
  input wire logic block_start,
  input wire logic [`CSB_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic irq_n,
  output logic status_serial_pin,
  output logic general_output_pin,
  output logic copy_permit_pin,
  output logic first_generation_pin,
  output logic cap_ready
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl2_q;
  logic [7:0] irqen_q;
  logic xfer_flag_q;
  logic copy_evt;
  wire inhibit = ctrl2_q[`CSB_INHIBIT_BIT];
  wire ser_sel = ctrl2_q[`CSB_SERSEL_BIT];
  wire wr_ctrl2 = reg_wr && reg_addr == `CSB_CTRL2_ADDR;
  wire wr_irqen = reg_wr && reg_addr == `CSB_IRQEN_ADDR;
  wire rd_flags = reg_rd && reg_addr == `CSB_FLAGS_ADDR;
  wire in_stat = reg_addr >= `CSB_STAT_A0_ADDR &&
    reg_addr <= `CSB_STAT_END_ADDR;
  wire [`CSB_ADDR_W-1:0] stat_off = reg_addr - `CSB_STAT_A0_ADDR;
  wire [3:0] mem_index = in_stat ? stat_off[3:0] : 4'hF;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl2_q <= 8'h00;
      irqen_q <= 8'h00;
      xfer_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl2)
        ctrl2_q <= reg_wdata;
      if (wr_irqen)
        irqen_q <= reg_wdata;
      if (copy_evt)
        xfer_flag_q <= 1'b1;
      else if (rd_flags)
        xfer_flag_q <= 1'b0;
    end
  end
  assign irq_n = !(xfer_flag_q && irqen_q[`CSB_XFER_BIT]);
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] mem_rdata;
  logic [1:0] rsel_q;
  logic rvalid_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsel_q <= 2'd0;
      rvalid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid_q <= reg_rd;
      rsel_q <= (reg_addr == `CSB_CTRL2_ADDR) ? 2'd1 :
        (reg_addr == `CSB_IRQEN_ADDR) ? 2'd2 :
        (reg_addr == `CSB_FLAGS_ADDR) ? 2'd3 : 2'd0;
    end
  end
  logic [7:0] flags_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= 8'h00;
    else if (clk_en)
      flags_q <= {7'h00, xfer_flag_q};
  end
  assign reg_rvalid = rvalid_q;
  assign reg_rdata = (rsel_q == 2'd1) ? ctrl2_q :
    (rsel_q == 2'd2) ? irqen_q :
    (rsel_q == 2'd3) ? flags_q : mem_rdata;
  // ----------------------------------------------------------------
  // capture path
  // ----------------------------------------------------------------
  logic pb_valid;
  logic [1:0] pb_data;
  cs_pair_buf #(.WIDTH(2)) cs_pair_buf_inst (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(cs_valid),
    .in_ready(cap_ready),
    .in_data({cs_bit_a, cs_bit_b}),
    .out_valid(pb_valid),
    .out_ready(1'b1),
    .out_data(pb_data)
  );
  logic [`CSB_CH_BITS-1:0] cap_a_q;
  logic [`CSB_CH_BITS-1:0] cap_b_q;
  logic [7:0] frame_q;
  logic [5:0] nbits_q;
  cs_buffer_pkg::cap_state_t state_q;
  logic [1:0] ser_pair_q;
  wire take = pb_valid;
  wire blk_end = take && frame_q == `CSB_BLOCK_FRAMES - 8'd1;
  wire want_copy = state_q == cs_buffer_pkg::ST_COPY;
  assign copy_evt = clk_en && want_copy && !inhibit;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_a_q <= '0;
      cap_b_q <= '0;
      frame_q <= 8'h00;
      nbits_q <= 6'h00;
      state_q <= cs_buffer_pkg::ST_IDLE;
      ser_pair_q <= 2'b00;
    end
    else if (clk_en)
    begin
      if (take && nbits_q < 6'(`CSB_CH_BITS))
      begin
        cap_a_q <= {cap_a_q[`CSB_CH_BITS-2:0], pb_data[1]};
        cap_b_q <= {cap_b_q[`CSB_CH_BITS-2:0], pb_data[0]};
        nbits_q <= nbits_q + 6'd1;
      end
      if (take)
      begin
        frame_q <= blk_end ? 8'h00 : frame_q + 8'd1;
        ser_pair_q <= pb_data;
      end
      case (state_q)
        cs_buffer_pkg::ST_IDLE:
          if (block_start)
          begin
            state_q <= cs_buffer_pkg::ST_FILL;
            frame_q <= 8'h00;
            nbits_q <= 6'h00;
          end
        cs_buffer_pkg::ST_FILL:
          if (blk_end)
            state_q <= cs_buffer_pkg::ST_COPY;
        cs_buffer_pkg::ST_COPY:
        begin
          state_q <= cs_buffer_pkg::ST_IDLE;
          nbits_q <= 6'h00;
        end
        default:
          state_q <= cs_buffer_pkg::ST_IDLE;
      endcase
    end
  end
  cs_host_mem cs_host_mem_inst (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(want_copy && !inhibit),
    .load_data({cap_a_q, cap_b_q}),
    .rd_index(mem_index),
    .rd_data(mem_rdata)
  );
  // ----------------------------------------------------------------
  // serial status output on both frame clock edges
  // ----------------------------------------------------------------
  logic [2:0] fclk_q;
  logic fclk_st_q;
  logic ser_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fclk_q <= 3'b000;
      fclk_st_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fclk_q <= {fclk_q[1:0], output_frame_clock};
      if (fclk_q[2] == fclk_q[1])
        fclk_st_q <= fclk_q[2];
    end
  end
  wire fclk_edge = clk_en && fclk_q[2] == fclk_q[1] &&
    fclk_q[2] != fclk_st_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_q <= 1'b0;
    end
    else if (fclk_edge)
    begin
      // last captured pair: a after a falling edge, b after a rising one
      ser_q <= fclk_st_q ? ser_pair_q[1] : ser_pair_q[0];
    end
  end
  logic copy_pin_q;
  logic first_generation_pin_pin_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copy_pin_q <= 1'b0;
      first_generation_pin_pin_q <= 1'b0;
    end
    else if (clk_en && copy_evt)
    begin
      copy_pin_q <= cap_a_q[`CSB_CH_BITS-1-`CSB_COPY_BIT];
      first_generation_pin_pin_q <= cap_a_q[`CSB_CH_BITS-1-`CSB_GEN_BIT];
    end
  end
  assign status_serial_pin = strapped_mode && port_master && ser_q;
  assign general_output_pin = !strapped_mode && ser_sel && ser_q;
  assign copy_permit_pin = strapped_mode && copy_pin_q;
  assign first_generation_pin = strapped_mode && first_generation_pin_pin_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_copy_needs_block;
    @(posedge clock) disable iff (!rst_n)
    copy_evt |-> $past(state_q == cs_buffer_pkg::ST_FILL);
  endproperty
  a_copy_needs_block: assert property (p_copy_needs_block)
    else $error("copy without finished block");
  property p_inhibit_blocks;
    @(posedge clock) disable iff (!rst_n)
    inhibit |-> !copy_evt;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks)
    else $error("copy while inhibited");
  property p_irq_after_copy;
    @(posedge clock) disable iff (!rst_n)
    copy_evt && irqen_q[`CSB_XFER_BIT] && !rd_flags |=> !irq_n;
  endproperty
  a_irq_after_copy: assert property (p_irq_after_copy)
    else $error("no interrupt after copy");
  property p_irq_masked;
    @(posedge clock) disable iff (!rst_n)
    !irqen_q[`CSB_XFER_BIT] |-> irq_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked interrupt asserted");
  property p_serial_master;
    @(posedge clock) disable iff (!rst_n)
    !port_master |-> !status_serial_pin;
  endproperty
  a_serial_master: assert property (p_serial_master)
    else $error("serial output while slave");
  property p_gpo_soft;
    @(posedge clock) disable iff (!rst_n)
    strapped_mode |-> !general_output_pin;
  endproperty
  a_gpo_soft: assert property (p_gpo_soft)
    else $error("general output in strapped mode");
  property p_strap_pins;
    @(posedge clock) disable iff (!rst_n)
    !strapped_mode |-> !copy_permit_pin && !first_generation_pin;
  endproperty
  a_strap_pins: assert property (p_strap_pins)
    else $error("strap pins driven in software mode");
  property p_rvalid;
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read answer missing");
  property p_full_block;
    @(posedge clock) disable iff (!rst_n)
    want_copy |-> nbits_q == 6'(`CSB_CH_BITS);
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("copy of a partly captured block");
  property p_unmapped_zero;
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && !in_stat && reg_addr != `CSB_CTRL2_ADDR &&
      reg_addr != `CSB_IRQEN_ADDR && reg_addr != `CSB_FLAGS_ADDR
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned data");
endmodule // cs_status_buffer

// [shared/cs_buffer_cfg.svh]
// register map, field positions and sizes of the status buffer
`ifndef CS_BUFFER_CFG_SVH
`define CS_BUFFER_CFG_SVH
`define CSB_ADDR_W 7
`define CSB_CTRL2_ADDR 7'h02
`define CSB_IRQEN_ADDR 7'h07
`define CSB_FLAGS_ADDR 7'h08
`define CSB_STAT_A0_ADDR 7'h19
`define CSB_STAT_B0_ADDR 7'h1E
`define CSB_STAT_END_ADDR 7'h22
`define CSB_INHIBIT_BIT 7
`define CSB_SERSEL_BIT 6
`define CSB_XFER_BIT 0
`define CSB_BYTES 5
`define CSB_CH_BITS 40
`define CSB_BLOCK_FRAMES 8'd192
`define CSB_COPY_BIT 2
`define CSB_GEN_BIT 15
`endif

// [shared/cs_buffer_pkg.sv]
// types shared by the status buffer files
package cs_buffer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_COPY = 3'b100
  } cap_state_t;
  typedef logic [7:0] byte_t;
endpackage

// [hdl/cs_pair_buf.sv]
// two-entry valid/ready buffer for captured status bit pairs
`timescale 1ns/100ps
module cs_pair_buf #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot0_q;
  logic [WIDTH-1:0] slot1_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count_q != 2'd2;
  assign out_valid = count_q != 2'd0;
  assign out_data = slot0_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot0_q <= '0;
      slot1_q <= '0;
      count_q <= 2'd0;
    end
    else if (clk_en)
    begin
      if (pop)
      begin
        slot0_q <= (count_q == 2'd2) ? slot1_q : in_data;
      end
      else if (push && count_q == 2'd0)
      begin
        slot0_q <= in_data;
      end
      if (push && ((count_q == 2'd2) || (count_q == 2'd1 && !pop)))
      begin
        slot1_q <= in_data;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 2'd1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 2'd1;
      end
    end
  end
endmodule // cs_pair_buf

// [hdl/cs_host_mem.sv]
// host-visible status memory, ten bytes, loaded whole in one cycle
`timescale 1ns/100ps
`include "cs_buffer_cfg.svh"
module cs_host_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [2*`CSB_CH_BITS-1:0] load_data,
  input wire logic [3:0] rd_index,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [0:2*`CSB_BYTES-1];
  genvar g;
  generate
    for (g = 0; g < 2*`CSB_BYTES; g++)
    begin : g_byte
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          mem_q[g] <= 8'h00;
        else if (clk_en && load)
          mem_q[g] <= load_data[2*`CSB_CH_BITS-1-8*g -: 8];
      end
    end
  endgenerate
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (clk_en)
      rd_data <= (rd_index < 4'(2*`CSB_BYTES)) ? mem_q[rd_index] : 8'h00;
  end
  property p_whole_load;
    @(posedge clock) disable iff (!rst_n)
    clk_en && load |=> mem_q[0] == $past(load_data[2*`CSB_CH_BITS-1 -: 8])
      && mem_q[2*`CSB_BYTES-1] == $past(load_data[7:0]);
  endproperty
  a_whole_load: assert property (p_whole_load)
    else $error("block copy not loaded whole");
endmodule // cs_host_mem

// [tb/cs_frame_source.sv]
// status bit source model feeding whole blocks to the buffer
`timescale 1ns/100ps
module cs_frame_source (
  input wire logic clock,
  input wire logic cap_ready,
  output logic block_start,
  output logic cs_valid,
  output logic cs_bit_a,
  output logic cs_bit_b
);
  initial
  begin
    block_start = 1'b0;
    cs_valid = 1'b0;
    cs_bit_a = 1'b0;
    cs_bit_b = 1'b0;
  end

  // ----------------------------------------
  // one block of 192 frames, msb sent first
  // ----------------------------------------
  task automatic send_block(input logic [39:0] a, input logic [39:0] b);
    int i;
    block_start = 1'b1;
    @(posedge clock);
    #1 block_start = 1'b0;
    for (i = 0; i < 192; i++)
    begin
      cs_valid = 1'b1;
      // frames past the stored bytes carry one on a, zero on b
      cs_bit_a = (i < 40) ? a[39-i] : 1'b1;
      cs_bit_b = (i < 40) ? b[39-i] : 1'b0;
      while (cap_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock);
      // released lines do not keep the last value
      #1 cs_valid = 1'b0;
      cs_bit_a = ~cs_bit_a;
      cs_bit_b = ~cs_bit_b;
      @(posedge clock);
      #1;
    end
  endtask
endmodule // cs_frame_source

// [tb/tb_channel_status_buffer.sv]
// self-checking bench for the channel status buffer
`timescale 1ns/100ps
`include "cs_buffer_cfg.svh"
module tb_channel_status_buffer;
  localparam logic [39:0] PA = 40'hC5A30F963C;
  localparam logic [39:0] PB = 40'h3B6ED107F8;
  localparam logic [39:0] PC = 40'h24015AC37E;
  localparam logic [39:0] PD = 40'h5E902CA741;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic strapped_mode = 1'b0;
  logic port_master = 1'b0;
  logic output_frame_clock = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic cs_valid, cs_bit_a, cs_bit_b, block_start, cap_ready;
  logic [7:0] reg_rdata;
  logic reg_rvalid, irq_n, status_serial_pin, general_output_pin;
  logic copy_permit_pin, first_generation_pin;
  logic [7:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int k;

  always #4 clock = ~clock;

  cs_status_buffer cs_status_buffer_inst (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .strapped_mode(strapped_mode), .port_master(port_master),
    .output_frame_clock(output_frame_clock), .cs_valid(cs_valid),
    .cs_bit_a(cs_bit_a), .cs_bit_b(cs_bit_b), .block_start(block_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq_n(irq_n),
    .status_serial_pin(status_serial_pin),
    .general_output_pin(general_output_pin),
    .copy_permit_pin(copy_permit_pin),
    .first_generation_pin(first_generation_pin), .cap_ready(cap_ready)
  );

  cs_frame_source cs_frame_source_inst (
    .clock(clock), .cap_ready(cap_ready), .block_start(block_start),
    .cs_valid(cs_valid), .cs_bit_a(cs_bit_a), .cs_bit_b(cs_bit_b)
  );

  // ----------------------------------------
  // access tasks, entered just after an edge
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic rd_expect(input logic [6:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01);
    check(reg_rdata, exp);
    @(posedge clock);
    #1;
  endtask

  task automatic check_block(input logic [39:0] a, input logic [39:0] b);
    for (k = 0; k < `CSB_BYTES; k++)
    begin
      rd_expect(`CSB_STAT_A0_ADDR + 7'(k), a[39-8*k -: 8]);
      rd_expect(`CSB_STAT_B0_ADDR + 7'(k), b[39-8*k -: 8]);
    end
  endtask

  task automatic wait_irq(input logic exp_low);
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < 30)
    begin
      @(posedge clock);
      #1 n++;
    end
    check({7'h00, irq_n}, {7'h00, ~exp_low});
  endtask

  task automatic results;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      error_cnt++;
      results;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    check({7'h00, irq_n}, 8'h01);
    rd_expect(`CSB_FLAGS_ADDR, 8'h00);
    rd_expect(7'h7F, 8'h00);
    rd_expect(`CSB_STAT_END_ADDR + 7'h01, 8'h00);
    reg_write(`CSB_IRQEN_ADDR, 8'h01);
    rd_expect(`CSB_IRQEN_ADDR, 8'h01);
    cs_frame_source_inst.send_block(PA, PB);
    wait_irq(1'b1);
    check_block(PA, PB);
    rd_expect(`CSB_FLAGS_ADDR, 8'h01);
    check({7'h00, irq_n}, 8'h01);
    rd_expect(`CSB_FLAGS_ADDR, 8'h00);
    // inhibited copy is skipped, old block stays
    reg_write(`CSB_CTRL2_ADDR, 8'h80);
    rd_expect(`CSB_CTRL2_ADDR, 8'h80);
    cs_frame_source_inst.send_block(PC, PD);
    wait_irq(1'b0);
    check_block(PA, PB);
    reg_write(`CSB_CTRL2_ADDR, 8'h00);
    cs_frame_source_inst.send_block(PC, PD);
    wait_irq(1'b1);
    check_block(PC, PD);
    rd_expect(`CSB_FLAGS_ADDR, 8'h01);
    rd_expect(`CSB_STAT_A0_ADDR + 7'h01, PC[31:24]);
    // strapped pins from channel one copy and generation bits
    strapped_mode = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rd = {6'h00, PC[37], PC[24]};
    check({6'h00, copy_permit_pin, first_generation_pin}, rd);
    // serial output held off while the audio port is a slave
    for (k = 0; k < 8; k++)
    begin
      output_frame_clock = ~output_frame_clock;
      repeat (6) @(posedge clock);
      #1;
      check({7'h00, status_serial_pin}, 8'h00);
    end
    // last pair a=1, b=0: b follows a rising edge, a a falling one
    port_master = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      output_frame_clock = ~output_frame_clock;
      repeat (6) @(posedge clock);
      #1;
      rd = {7'h00, ~output_frame_clock};
      check({7'h00, status_serial_pin}, rd);
    end
    // software mode routes the stream to the general output pin
    strapped_mode = 1'b0;
    reg_write(`CSB_CTRL2_ADDR, 8'h40);
    rd_expect(`CSB_CTRL2_ADDR, 8'h40);
    for (k = 0; k < 2; k++)
    begin
      output_frame_clock = ~output_frame_clock;
      repeat (6) @(posedge clock);
      #1;
      rd = {6'h00, ~output_frame_clock, 1'b0};
      check({6'h00, general_output_pin, status_serial_pin}, rd);
    end
    results;
  end
endmodule // tb_channel_status_buffer
